/* verilog/fcpl_map.svh */
// register offsets, field positions and reset values of the front-end config block
`ifndef FCPL_MAP_SVH
`define FCPL_MAP_SVH
`define FCPL_ADDR_CHAN_CLK 16'hE708
`define FCPL_ADDR_PORT_LOCK 16'hEA00
`define FCPL_CHAN_SEL_LSB 0
`define FCPL_CHAN_SEL_MSB 3
`define FCPL_CLK_DIS_BIT 6
`define FCPL_SOFT_RST_BIT 7
`define FCPL_LOCK_BIT 0
`define FCPL_CHAN_SEL_RST 4'hF
`define FCPL_CHAN_CLK_RST 8'h0F
`define FCPL_CHAN_CLK_WMASK 8'hCF
`define FCPL_TOGGLES_FOR_SPI 2'h3
`define FCPL_CLK_DIV_HALF 4'h3
`endif

/* verilog/fcpl_pkg.sv */
// types shared by the front-end config block
package fcpl_pkg;
   typedef enum logic {FCPL_PORT_I2C, FCPL_PORT_SPI} fcpl_port_t;
endpackage

/* verilog/fcpl_port_select.sv */
// host port selection: select pin toggle counting and lock
`include "fcpl_map.svh"
module fcpl_port_select import fcpl_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic select_or_stream_active_pin,
   input wire logic lock_write,
   input wire logic lock_data,
   output fcpl_port_t port_sel,
   output logic port_locked
);
   logic pin_d_r; // previous pin level for edge detect
   logic [1:0] toggle_cnt_r; // toggles seen while unlocked
   fcpl_port_t port_r;
   logic locked_r;
   logic init_r; // first sample seen, avoids a false edge at reset release
   wire pin_toggle = init_r & (select_or_stream_active_pin != pin_d_r);
   wire third_toggle = pin_toggle & (toggle_cnt_r == 2'(`FCPL_TOGGLES_FOR_SPI - 2'h1));
   // lock: i2c needs data bit 1, spi locks on any write
   wire lock_now = lock_write & ((port_r == FCPL_PORT_SPI) | lock_data);
   // pin history
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_d_r <= 1'b0;
         init_r <= 1'b0;
      end else begin
         pin_d_r <= select_or_stream_active_pin;
         init_r <= 1'b1;
      end
   end
   // toggle counter and protocol choice
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         toggle_cnt_r <= 2'h0;
         port_r <= FCPL_PORT_I2C;
      end else if (!locked_r && port_r == FCPL_PORT_I2C && pin_toggle) begin
         if (third_toggle) begin
            port_r <= FCPL_PORT_SPI;
         end
         toggle_cnt_r <= toggle_cnt_r + 2'h1;
      end
   end
   // lock only falls with hardware reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         locked_r <= 1'b0;
      end else if (lock_now) begin
         locked_r <= 1'b1;
      end
   end
   assign port_sel = port_r;
   assign port_locked = locked_r;
endmodule

/* verilog/fcpl_top.sv */
// front-end channel/clock control and serial port lock register bank
// How it works
// - bits 0-3 pick temperature or aux input
// - clock disable holds front-end clocks high
// - writing soft reset bit resets front ends
// - three select toggles switch to spi
// - i2c lock bit ignores select toggles
// - any lock register write locks spi
// - lock holds until hardware reset
// - reserved bits read zero, no function
`include "fcpl_map.svh"
module fcpl_top import fcpl_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic select_or_stream_active_pin,
   output logic phase_a_aux_channel_select,
   output logic phase_b_aux_channel_select,
   output logic phase_c_aux_channel_select,
   output logic neutral_aux_channel_select,
   output logic [3:0] frontend_clock_output,
   output logic frontend_soft_reset,
   output fcpl_port_t port_sel,
   output logic port_locked
);
   logic [7:0] chan_clk_r; // channel select and clock disable; soft reset bit held at zero
   logic lock_bit_r; // stored lock bit, readable
   logic soft_rst_r; // one-cycle soft reset pulse
   logic [3:0] div_r; // clock divider for the front-end clocks
   logic fe_clk_r;
   logic [3:0] fe_clk_out_r;
   // register decode
   wire hit_chan = (reg_addr == `FCPL_ADDR_CHAN_CLK);
   wire hit_lock = (reg_addr == `FCPL_ADDR_PORT_LOCK);
   wire wr_chan = reg_wr & hit_chan;
   wire wr_lock = reg_wr & hit_lock;
   wire clk_dis = chan_clk_r[`FCPL_CLK_DIS_BIT];
   // reserved bits masked on write so they stay zero
   wire [7:0] chan_wval = reg_wdata & `FCPL_CHAN_CLK_WMASK;
   // channel/clock register; soft reset bit never stored
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chan_clk_r <= `FCPL_CHAN_CLK_RST;
      end else if (wr_chan) begin
         chan_clk_r <= {1'b0, chan_wval[6:0]};
      end
   end
   // soft reset issued as a single pulse on the write
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= wr_chan & reg_wdata[`FCPL_SOFT_RST_BIT];
      end
   end
   // lock bit storage: sticky, write cannot clear it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lock_bit_r <= 1'b0;
      end else if (wr_lock && reg_wdata[`FCPL_LOCK_BIT]) begin
         lock_bit_r <= 1'b1;
      end
   end
   // read mux, unmapped reads return zero
   assign reg_rdata = hit_chan ? chan_clk_r :
                      hit_lock ? {7'h0, lock_bit_r} : 8'h00;
   // free-running divider for the front-end clocks
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 4'h0;
         fe_clk_r <= 1'b0;
      end else if (div_r == `FCPL_CLK_DIV_HALF) begin
         div_r <= 4'h0;
         fe_clk_r <= ~fe_clk_r;
      end else begin
         div_r <= div_r + 4'h1;
      end
   end
   // clock outputs held high while disabled
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fe_clk_out_r <= 4'h0;
      end else begin
         fe_clk_out_r <= clk_dis ? 4'hF : {4{fe_clk_r}};
      end
   end
   // channel routing outputs: 1 aux input, 0 temperature
   assign phase_a_aux_channel_select = chan_clk_r[`FCPL_CHAN_SEL_LSB];
   assign phase_b_aux_channel_select = chan_clk_r[`FCPL_CHAN_SEL_LSB + 1];
   assign phase_c_aux_channel_select = chan_clk_r[`FCPL_CHAN_SEL_LSB + 2];
   assign neutral_aux_channel_select = chan_clk_r[`FCPL_CHAN_SEL_MSB];
   assign frontend_clock_output = fe_clk_out_r;
   assign frontend_soft_reset = soft_rst_r;
   // protocol selection and lock
   fcpl_port_select u_port (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .select_or_stream_active_pin(select_or_stream_active_pin),
      .lock_write(wr_lock),
      .lock_data(reg_wdata[`FCPL_LOCK_BIT]),
      .port_sel(port_sel),
      .port_locked(port_locked)
   );
endmodule

/* test/fcpl_chk.sv */
// port assertions for the front-end config block
`include "fcpl_map.svh"
module fcpl_chk import fcpl_pkg::*; (
   input logic clk_sys,
   input logic rst_n,
   input logic reg_wr,
   input logic [15:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic [7:0] reg_rdata,
   input logic select_or_stream_active_pin,
   input logic phase_a_aux_channel_select,
   input logic phase_b_aux_channel_select,
   input logic phase_c_aux_channel_select,
   input logic neutral_aux_channel_select,
   input logic [3:0] frontend_clock_output,
   input logic frontend_soft_reset,
   input fcpl_port_t port_sel,
   input logic port_locked
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // write decodes per register
   wire wr_cc = reg_wr && reg_addr == `FCPL_ADDR_CHAN_CLK;
   wire wr_pl = reg_wr && reg_addr == `FCPL_ADDR_PORT_LOCK;
   wire [3:0] sel = {neutral_aux_channel_select, phase_c_aux_channel_select,
      phase_b_aux_channel_select, phase_a_aux_channel_select};
   soft_pulse_a: assert property (wr_cc && reg_wdata[7] |=> frontend_soft_reset)
      else $error("soft reset pulse missing");
   pulse_one_a: assert property (frontend_soft_reset |=> !frontend_soft_reset)
      else $error("soft reset longer than one cycle");
   chan_sel_a: assert property (wr_cc |=> sel == $past(reg_wdata[3:0]))
      else $error("channel selects not updated");
   clk_high_a: assert property (wr_cc && reg_wdata[6] |=> ##1 (frontend_clock_output == 4'hF) [*3])
      else $error("front-end clocks not held high");
   lock_hold_a: assert property (port_locked |=> port_locked && $stable(port_sel))
      else $error("lock or port changed");
   spi_lock_a: assert property (wr_pl && port_sel == FCPL_PORT_SPI |=> port_locked)
      else $error("spi write did not lock");
   i2c_lock_a: assert property (wr_pl && reg_wdata[0] |=> port_locked)
      else $error("lock write ignored");
   rsv_zero_a: assert property (reg_addr == `FCPL_ADDR_CHAN_CLK |-> (reg_rdata & 8'hB0) == 0)
      else $error("reserved bits read nonzero");
   zero_nolock_a: assert property (wr_pl && !reg_wdata[0] && port_sel == FCPL_PORT_I2C
      && !port_locked |=> !port_locked)
      else $error("zero write locked i2c");
   cover property (frontend_soft_reset);
   cover property (port_locked && port_sel == FCPL_PORT_SPI);
   cover property (port_locked && port_sel == FCPL_PORT_I2C);
endmodule

/* test/fcpl_host.sv */
// host model: register writes, address for reads and select pin toggles
module fcpl_host (
   input logic clk_sys,
   output logic reg_wr = 1'b0,
   output logic [15:0] reg_addr = 16'hE708,
   output logic [7:0] reg_wdata = 8'h00,
   output logic select_or_stream_active_pin = 1'b0
);
   // one-cycle strobe, changed on the falling edge only
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   // pin changes spaced two cycles so each is seen
   task automatic flip(input int n);
      repeat (n) begin
         @(negedge clk_sys);
         select_or_stream_active_pin = ~select_or_stream_active_pin;
         @(negedge clk_sys);
      end
   endtask
endmodule

/* test/frontend_config_port_lock_bench.sv */
// bench: host-model sequences with checked port values
`include "fcpl_map.svh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_mismatch++; \
   $display("Error %s exp %h got %h", n, e, s); end end
module frontend_config_port_lock_bench import fcpl_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr, select_or_stream_active_pin, frontend_soft_reset, port_locked;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic phase_a_aux_channel_select, phase_b_aux_channel_select;
   logic phase_c_aux_channel_select, neutral_aux_channel_select;
   logic [3:0] frontend_clock_output;
   fcpl_port_t port_sel;
   int n_checks = 0;
   int n_mismatch = 0;
   always #4 clk_sys = ~clk_sys;
   fcpl_host fcpl_host_i (.*);
   fcpl_top fcpl_top_i (.*);
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic reset_dut;
      rst_n = 1'b0;
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
   endtask
   // watchdog well beyond the under 100 cycles of the tests
   initial begin
      #20000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      reset_dut();
      `CHK("chan rst", 8'h0F, reg_rdata)
      fcpl_host_i.wr(16'hE708, 8'hFF);
      `CHK("soft rst", 1'b1, frontend_soft_reset)
      `CHK("chan ff", 8'h4F, reg_rdata)
      repeat (2) @(negedge clk_sys);
      `CHK("soft rst end", 1'b0, frontend_soft_reset)
      `CHK("clk out", 4'hF, frontend_clock_output)
      fcpl_host_i.wr(16'hE708, 8'h00);
      `CHK("sel temp", 4'h0, {neutral_aux_channel_select, phase_c_aux_channel_select, phase_b_aux_channel_select, phase_a_aux_channel_select})
      fcpl_host_i.wr(16'hEA00, 8'h00);
      `CHK("no lock", 1'b0, port_locked)
      fcpl_host_i.flip(2);
      `CHK("two flips", FCPL_PORT_I2C, port_sel)
      fcpl_host_i.flip(1);
      `CHK("spi", FCPL_PORT_SPI, port_sel)
      fcpl_host_i.wr(16'hEA00, 8'hFE);
      `CHK("spi lock", 1'b1, port_locked)
      fcpl_host_i.wr(16'hEA00, 8'hFF);
      `CHK("lock rsv", 8'h01, reg_rdata)
      reset_dut();
      `CHK("port after rst", FCPL_PORT_I2C, port_sel)
      fcpl_host_i.wr(16'hEA00, 8'h01);
      fcpl_host_i.flip(3);
      `CHK("i2c kept", FCPL_PORT_I2C, port_sel)
      `CHK("i2c locked", 1'b1, port_locked)
      fcpl_host_i.wr(16'h1234, 8'hFF);
      `CHK("unmapped", 8'h00, reg_rdata)
      give_verdict();
   end
endmodule
bind fcpl_top fcpl_chk fcpl_chk_i (.*);
